/* File: fes_pkg.sv */
package fes_pkg;

  localparam int ADDR_W = 26;
  localparam int DATA_W = 16;
  localparam int CLK_PS = 4000;

  // Bus timing, least values in ns
  localparam int T_WP_NS   = 35;
  localparam int T_WPH_NS  = 30;
  localparam int T_ACC_NS  = 130;
  localparam int T_OEPH_NS = 20;
  localparam int T_BUSY_NS = 90;
  localparam int SYNC_CYC  = 2;

  // Typical algorithm times and longest erase time
  localparam int T_PROG_US     = 60;
  localparam int T_PROG_ACC_US = 54;
  localparam int T_SERASE_MS   = 500;
  localparam int T_TMO_MS      = 3500;

  function automatic int ns2cyc(input int ns);
    int c;
    c = (ns * 1000 + CLK_PS - 1) / CLK_PS;
    return (c < 1) ? 1 : c;
  endfunction : ns2cyc

  localparam int WP_CYC   = ns2cyc(T_WP_NS);
  localparam int WPH_CYC  = ns2cyc(T_WPH_NS);
  localparam int ACC_CYC  = ns2cyc(T_ACC_NS) + SYNC_CYC;
  localparam int OEPH_CYC = ns2cyc(T_OEPH_NS);
  localparam int BUSY_CYC = ns2cyc(T_BUSY_NS);

  localparam int HOLD_PROG_CYC_DEF     = T_PROG_US * 1000000 / CLK_PS;
  localparam int HOLD_PROG_ACC_CYC_DEF = T_PROG_ACC_US * 1000000 / CLK_PS;
  localparam int HOLD_ERASE_CYC_DEF    = T_SERASE_MS * 1000 / CLK_PS * 1000000;
  localparam int TMO_CYC_DEF           = T_TMO_MS * 1000 / CLK_PS * 1000000;

  localparam logic [ADDR_W-1:0] ADDR_UNLOCK_A = 26'h0000555;
  localparam logic [ADDR_W-1:0] ADDR_UNLOCK_B = 26'h00002aa;
  localparam logic [DATA_W-1:0] CODE_UNLOCK_A = 16'h00aa;
  localparam logic [DATA_W-1:0] CODE_UNLOCK_B = 16'h0055;
  localparam logic [DATA_W-1:0] CODE_PROGRAM  = 16'h00a0;
  localparam logic [DATA_W-1:0] CODE_ERASE    = 16'h0080;
  localparam logic [DATA_W-1:0] CODE_SECTOR   = 16'h0030;
  localparam logic [DATA_W-1:0] CODE_CHIP     = 16'h0010;

  localparam logic [2:0] LAST_PROG  = 3'h3;
  localparam logic [2:0] LAST_ERASE = 3'h5;

  localparam int POLLING_STATUS_BIT  = 7;
  localparam int RUN_TOGGLE_BIT      = 6;
  localparam int SUSPEND_TOGGLE_BIT  = 2;

  typedef enum logic [1:0] {
    OP_PROG   = 2'b00,
    OP_SERASE = 2'b01,
    OP_CERASE = 2'b10,
    OP_NONE   = 2'b11
  } fes_op_type;

  typedef struct packed {
    fes_op_type        op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } fes_cmd_type;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } fes_bus_type;

endpackage : fes_pkg

/* File: fes_host.sv */
`timescale 1ns/1ps
// Function
// - Sector erase ends 55h@2AAh then 30h@sector.
// - Chip erase ends with 10h written to 555h.
// - Status reads back to back, chip select held.
// - Output enable alone delimits reads; chip select stays low.
module fes_host
  import fes_pkg::*;
#(
  parameter int HOLD_PROG_CYC     = fes_pkg::HOLD_PROG_CYC_DEF,
  parameter int HOLD_PROG_ACC_CYC = fes_pkg::HOLD_PROG_ACC_CYC_DEF,
  parameter int HOLD_ERASE_CYC    = fes_pkg::HOLD_ERASE_CYC_DEF,
  parameter int TMO_CYC           = fes_pkg::TMO_CYC_DEF
)(
  input  wire logic                        CLK_IN,
  input  wire logic                        RESETN_IN,
  input  wire logic                        CMD_VALID_IN,
  input  wire fes_pkg::fes_cmd_type        CMD_IN,
  input  wire logic                        ACCEL_IN,
  output logic                             CMD_READY_OUT,
  output logic                             DONE_OUT,
  output logic                             TIMEOUT_OUT,
  output logic [fes_pkg::DATA_W-1:0]       STATUS_OUT,
  output logic [fes_pkg::ADDR_W-1:0]       FL_ADDR_OUT,
  output logic [fes_pkg::DATA_W-1:0]       FL_DQ_OUT,
  output logic                             FL_DQ_OE_N_OUT,
  input  wire logic [fes_pkg::DATA_W-1:0]  FL_DQ_IN,
  output logic                             FL_CE_N_OUT,
  output logic                             FL_OE_N_OUT,
  output logic                             FL_WE_N_OUT,
  input  wire logic                        FL_READY_BUSY_N_IN
);
  import fes_pkg::*;

  if (HOLD_PROG_CYC < BUSY_CYC || HOLD_PROG_ACC_CYC < BUSY_CYC ||
      HOLD_ERASE_CYC < BUSY_CYC || TMO_CYC <= HOLD_ERASE_CYC)
  begin : g_param_check
    $error("fes_host: holdoff below busy delay or timeout not above holdoff");
  end

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_WR_LOW  = 3'b001,
    ST_WR_HIGH = 3'b010,
    ST_HOLD    = 3'b011,
    ST_RD_LOW  = 3'b100,
    ST_RD_HIGH = 3'b101
  } fes_state_type;

  fes_state_type       state_r;
  fes_cmd_type         cmd_r;
  logic [31:0]         cnt_r;
  logic [31:0]         tmo_cnt_r;
  logic [2:0]          step_r;
  logic [DATA_W-1:0]   prev_r;
  logic                prev_vld_r;
  logic                fin_r;
  logic [DATA_W-1:0]   dq_m_r;
  logic [DATA_W-1:0]   dq_s_r;
  logic                rb_m_r;
  logic                rb_s_r;
  fes_bus_type         word_nxt;
  logic                settled;
  logic                tmo_hit;

  // Unlock cycles, then the op's final cycles
  function automatic fes_bus_type cmd_word(input fes_op_type op, input logic [2:0] st,
                                           input fes_cmd_type c);
    fes_bus_type w;
    w = '{addr: ADDR_UNLOCK_A, data: CODE_UNLOCK_A};
    case (st)
      3'h1, 3'h4:
        w = '{addr: ADDR_UNLOCK_B, data: CODE_UNLOCK_B};
      3'h2:
        w.data = (op == OP_PROG) ? CODE_PROGRAM : CODE_ERASE;
      3'h3:
        if (op == OP_PROG)
          w = '{addr: c.addr, data: c.data};
      3'h5:
        if (op == OP_SERASE)
          w = '{addr: c.addr, data: CODE_SECTOR};
        else
          w.data = CODE_CHIP;
      default:
        w = '{addr: ADDR_UNLOCK_A, data: CODE_UNLOCK_A};
    endcase
    return w;
  endfunction : cmd_word

  function automatic logic [2:0] last_step(input fes_op_type op);
    return (op == OP_PROG) ? LAST_PROG : LAST_ERASE;
  endfunction : last_step

  assign word_nxt = cmd_word(cmd_r.op, step_r + 3'h1, cmd_r);

  // Done once the run toggle bit holds still across two reads, the
  // polling bit shows true data on a program and ready/busy has been released
  assign settled = prev_vld_r
                && (dq_s_r[RUN_TOGGLE_BIT] == prev_r[RUN_TOGGLE_BIT])
                && (cmd_r.op != OP_PROG
                    || dq_s_r[POLLING_STATUS_BIT] == cmd_r.data[POLLING_STATUS_BIT])
                && rb_s_r;
  assign tmo_hit = (tmo_cnt_r >= 32'(TMO_CYC - 1));

  // Pins from outside pass two flops before use
  always_ff @(posedge CLK_IN)
  begin
    if (!RESETN_IN)
    begin
      dq_m_r <= '0;
      dq_s_r <= '0;
      rb_m_r <= 1'b1;
      rb_s_r <= 1'b1;
    end
    else
    begin
      dq_m_r <= FL_DQ_IN;
      dq_s_r <= dq_m_r;
      rb_m_r <= FL_READY_BUSY_N_IN;
      rb_s_r <= rb_m_r;
    end
  end

  // Watchdog over the whole embedded algorithm
  always_ff @(posedge CLK_IN)
  begin
    if (!RESETN_IN || state_r == ST_IDLE)
      tmo_cnt_r <= '0;
    else if (!tmo_hit)
      tmo_cnt_r <= tmo_cnt_r + 32'h1;
  end

  always_ff @(posedge CLK_IN)
  begin
    if (!RESETN_IN)
    begin
      state_r        <= ST_IDLE;
      cmd_r          <= '{op: OP_NONE, addr: '0, data: '0};
      cnt_r          <= '0;
      step_r         <= '0;
      prev_r         <= '0;
      prev_vld_r     <= 1'b0;
      fin_r          <= 1'b0;
      CMD_READY_OUT  <= 1'b0;
      DONE_OUT       <= 1'b0;
      TIMEOUT_OUT    <= 1'b0;
      STATUS_OUT     <= '0;
      FL_ADDR_OUT    <= '0;
      FL_DQ_OUT      <= '0;
      FL_DQ_OE_N_OUT <= 1'b1;
      FL_CE_N_OUT    <= 1'b1;
      FL_OE_N_OUT    <= 1'b1;
      FL_WE_N_OUT    <= 1'b1;
    end
    else
    begin
      DONE_OUT <= 1'b0;
      case (state_r)
        ST_IDLE:
        begin
          CMD_READY_OUT <= 1'b1;
          if (CMD_READY_OUT && CMD_VALID_IN && CMD_IN.op != OP_NONE)
          begin
            // Chip select stays low through the whole command and polling
            cmd_r          <= CMD_IN;
            CMD_READY_OUT  <= 1'b0;
            step_r         <= '0;
            fin_r          <= 1'b0;
            FL_ADDR_OUT    <= ADDR_UNLOCK_A;
            FL_DQ_OUT      <= CODE_UNLOCK_A;
            FL_DQ_OE_N_OUT <= 1'b0;
            FL_CE_N_OUT    <= 1'b0;
            FL_WE_N_OUT    <= 1'b0;
            cnt_r          <= 32'(WP_CYC - 1);
            state_r        <= ST_WR_LOW;
          end
        end
        ST_WR_LOW:
        begin
          cnt_r <= cnt_r - 32'h1;
          if (cnt_r == '0)
          begin
            FL_WE_N_OUT <= 1'b1;
            cnt_r       <= 32'(WPH_CYC - 1);
            state_r     <= ST_WR_HIGH;
          end
        end
        ST_WR_HIGH:
        begin
          cnt_r <= cnt_r - 32'h1;
          if (cnt_r == '0 && step_r == last_step(cmd_r.op))
          begin
            // Holdoff covers the busy delay; polling before the typical
            // time only burns bus cycles
            FL_DQ_OE_N_OUT <= 1'b1;
            FL_ADDR_OUT    <= cmd_r.addr;
            prev_vld_r     <= 1'b0;
            state_r        <= ST_HOLD;
            if (cmd_r.op != OP_PROG)
              cnt_r <= 32'(HOLD_ERASE_CYC - 1);
            else if (ACCEL_IN)
              cnt_r <= 32'(HOLD_PROG_ACC_CYC - 1);
            else
              cnt_r <= 32'(HOLD_PROG_CYC - 1);
          end
          else if (cnt_r == '0)
          begin
            step_r      <= step_r + 3'h1;
            FL_ADDR_OUT <= word_nxt.addr;
            FL_DQ_OUT   <= word_nxt.data;
            FL_WE_N_OUT <= 1'b0;
            cnt_r       <= 32'(WP_CYC - 1);
            state_r     <= ST_WR_LOW;
          end
        end
        ST_HOLD:
        begin
          cnt_r <= cnt_r - 32'h1;
          if (cnt_r == '0)
          begin
            FL_OE_N_OUT <= 1'b0;
            cnt_r       <= 32'(ACC_CYC - 1);
            state_r     <= ST_RD_LOW;
          end
        end
        ST_RD_LOW:
        begin
          cnt_r <= cnt_r - 32'h1;
          if (cnt_r == '0)
          begin
            // Output enable pulse alone advances the toggle bits
            FL_OE_N_OUT <= 1'b1;
            prev_r      <= dq_s_r;
            prev_vld_r  <= 1'b1;
            STATUS_OUT  <= dq_s_r;
            fin_r       <= settled || tmo_hit;
            TIMEOUT_OUT <= tmo_hit && !settled;
            cnt_r       <= 32'(OEPH_CYC - 1);
            state_r     <= ST_RD_HIGH;
          end
        end
        ST_RD_HIGH:
        begin
          cnt_r <= cnt_r - 32'h1;
          if (cnt_r == '0 && fin_r)
          begin
            FL_CE_N_OUT   <= 1'b1;
            DONE_OUT      <= 1'b1;
            CMD_READY_OUT <= 1'b1;
            state_r       <= ST_IDLE;
          end
          else if (cnt_r == '0)
          begin
            FL_OE_N_OUT <= 1'b0;
            cnt_r       <= 32'(ACC_CYC - 1);
            state_r     <= ST_RD_LOW;
          end
        end
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RESETN_IN);

  sequence s_final_write;
    state_r == ST_WR_LOW && step_r == LAST_ERASE;
  endsequence

  sequence s_read_gap;
    (FL_OE_N_OUT && !FL_CE_N_OUT)[*5] ##1 !FL_OE_N_OUT;
  endsequence

  chk_sector_final_cycle: assert property (
    s_final_write and (cmd_r.op == OP_SERASE)
      |-> FL_ADDR_OUT == cmd_r.addr && FL_DQ_OUT == CODE_SECTOR
          && $past(FL_DQ_OUT, 17) == CODE_UNLOCK_B)
    else $error("sector erase final cycles wrong");

  chk_chip_final_cycle: assert property (
    s_final_write and (cmd_r.op == OP_CERASE)
      |-> FL_ADDR_OUT == ADDR_UNLOCK_A && FL_DQ_OUT == CODE_CHIP)
    else $error("chip erase final cycle wrong");

  chk_read_delimit_oe: assert property (
    $rose(FL_OE_N_OUT) && !fin_r && state_r == ST_RD_HIGH |-> s_read_gap)
    else $error("status read not delimited by output enable pulse");

  chk_cs_held_polling: assert property (
    state_r == ST_RD_LOW |-> !FL_CE_N_OUT && !FL_OE_N_OUT && FL_DQ_OE_N_OUT)
    else $error("chip select or data drive wrong during status read");

  chk_we_pulse_width: assert property (
    $fell(FL_WE_N_OUT) |-> (!FL_WE_N_OUT)[*8] ##1 !FL_WE_N_OUT ##1 FL_WE_N_OUT)
    else $error("write pulse not nine cycles");

  chk_done_after_settle: assert property (
    state_r == ST_RD_LOW && cnt_r == '0 && settled |=> fin_r && !TIMEOUT_OUT
      ##5 DONE_OUT && CMD_READY_OUT && FL_CE_N_OUT)
    else $error("settled status did not finish the operation");

endmodule : fes_host

/* File: fes_flash_model.sv */
`timescale 1ns/1ps
module fes_flash_model
  import fes_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic [DATA_W-1:0] dq_in,
  input  wire logic              ce_n_in,
  input  wire logic              oe_n_in,
  input  wire logic              we_n_in,
  input  wire logic [31:0]       busy_len_in,
  output logic [DATA_W-1:0]      dq_out,
  output logic                   ready_busy_n_out,
  output fes_op_type             op_out,
  output logic [ADDR_W-1:0]      op_addr_out,
  output logic [DATA_W-1:0]      op_data_out
);
  logic [ADDR_W+DATA_W-1:0] hist[$];
  logic [DATA_W-1:0]        mem[logic [ADDR_W-1:0]];
  logic [ADDR_W-1:0]        k;
  logic                     tog_r = 1'b0;
  int                       busy_r = 0;
  initial
  begin
    ready_busy_n_out = 1'b1;
    op_out = OP_NONE;
    dq_out = 16'h0000;
  end
  task automatic start(input fes_op_type op);
    op_out = op;
    op_addr_out = addr_in;
    op_data_out = dq_in;
    busy_r = busy_len_in;
    ready_busy_n_out = 1'b0;
    hist.delete();
  endtask : start
  always @(posedge we_n_in)
    if (!ce_n_in)
    begin
      hist.push_front({addr_in, dq_in});
      if (hist.size() >= 4 && {hist[3], hist[2], hist[1]} == {ADDR_UNLOCK_A, CODE_UNLOCK_A,
          ADDR_UNLOCK_B, CODE_UNLOCK_B, ADDR_UNLOCK_A, CODE_PROGRAM})
        start(OP_PROG);
      else if (hist.size() >= 6 && {hist[5], hist[4], hist[3], hist[2], hist[1]} ==
          {ADDR_UNLOCK_A, CODE_UNLOCK_A, ADDR_UNLOCK_B, CODE_UNLOCK_B, ADDR_UNLOCK_A,
           CODE_ERASE, ADDR_UNLOCK_A, CODE_UNLOCK_A, ADDR_UNLOCK_B, CODE_UNLOCK_B})
      begin
        if (dq_in == CODE_SECTOR)
          start(OP_SERASE);
        else if ({addr_in, dq_in} == {ADDR_UNLOCK_A, CODE_CHIP})
          start(OP_CERASE);
      end
      if (hist.size() > 6)
        void'(hist.pop_back());
    end
  always @(posedge clk_in)
    if (busy_r > 0)
    begin
      busy_r = busy_r - 1;
      if (busy_r == 0)
      begin
        if (op_out == OP_PROG)
          mem[op_addr_out] = op_data_out;
        else if (op_out == OP_CERASE)
          mem.delete();
        else if (mem.first(k))
          do
            if (k[ADDR_W-1:16] == op_addr_out[ADDR_W-1:16])
              mem.delete(k);
          while (mem.next(k));
        ready_busy_n_out = 1'b1;
      end
    end
  // Either strobe rising ends a status read
  always @(posedge oe_n_in or posedge ce_n_in)
    if ((oe_n_in ^ ce_n_in) && busy_r > 0)
      tog_r = ~tog_r;
  // Released bus shows a changing pattern, not the last word
  always @(ce_n_in or oe_n_in or addr_in or tog_r or ready_busy_n_out)
    if (ce_n_in || oe_n_in)
      dq_out = ~dq_out;
    else if (busy_r > 0)
      dq_out = {8'h00, op_out == OP_PROG ? ~op_data_out[7] : 1'b0, tog_r, 6'h00};
    else
      dq_out = mem.exists(addr_in) ? mem[addr_in] : 16'hffff;
endmodule : fes_flash_model

/* File: fes_host_tb_top.sv */
`timescale 1ns/1ps
module fes_host_tb_top;
  import fes_pkg::*;
  localparam int TMO = 2000;
  logic              clk = 1'b0, rst_n = 1'b0, cmd_valid = 1'b0, accel = 1'b0;
  fes_cmd_type       cmd = '0;
  logic              cmd_ready, done, tmo, dq_oe_n, ce_n, oe_n, we_n, rb_n;
  logic [DATA_W-1:0] status, dq_host, dq_flash, m_data;
  logic [ADDR_W-1:0] fl_addr, m_addr;
  fes_op_type        m_op;
  wire  [DATA_W-1:0] dq_bus = dq_oe_n ? dq_flash : dq_host;
  int                busy_len = 10, failures = 0, compares = 0;
  logic [DATA_W-1:0] exp_q[$];
  always #2 clk = ~clk;
  fes_host #(.HOLD_PROG_CYC(40), .HOLD_PROG_ACC_CYC(30), .HOLD_ERASE_CYC(100), .TMO_CYC(TMO)) dut (
    .CLK_IN(clk), .RESETN_IN(rst_n), .CMD_VALID_IN(cmd_valid), .CMD_IN(cmd), .ACCEL_IN(accel),
    .CMD_READY_OUT(cmd_ready), .DONE_OUT(done), .TIMEOUT_OUT(tmo), .STATUS_OUT(status),
    .FL_ADDR_OUT(fl_addr), .FL_DQ_OUT(dq_host), .FL_DQ_OE_N_OUT(dq_oe_n), .FL_DQ_IN(dq_bus),
    .FL_CE_N_OUT(ce_n), .FL_OE_N_OUT(oe_n), .FL_WE_N_OUT(we_n), .FL_READY_BUSY_N_IN(rb_n));
  fes_flash_model flash (
    .clk_in(clk), .addr_in(fl_addr), .dq_in(dq_bus), .ce_n_in(ce_n), .oe_n_in(oe_n),
    .we_n_in(we_n), .busy_len_in(busy_len), .dq_out(dq_flash), .ready_busy_n_out(rb_n),
    .op_out(m_op), .op_addr_out(m_addr), .op_data_out(m_data));
  task automatic end_of_test();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_of_test
  task automatic chk_val(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_val
  task automatic run(input string nm, input fes_op_type op, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d, input logic acc, input int blen, input logic to);
    int                n;
    logic [DATA_W-1:0] e;
    n = 0;
    do @(negedge clk); while (cmd_ready !== 1'b1);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd <= '{op: op, addr: a, data: d};
    accel <= acc;
    busy_len <= blen;
    exp_q.push_back(op == OP_PROG ? d : 16'hffff);
    @(posedge clk);
    cmd_valid <= 1'b0;
    while (done !== 1'b1 && n < TMO + 9000)
    begin
      @(negedge clk);
      n++;
    end
    e = exp_q.pop_front();
    chk_val("done", 1, {31'h0, done});
    chk_val("timeout", {31'h0, to}, {31'h0, tmo});
    chk_val("op", op, m_op);
    chk_val("addr", op == OP_CERASE ? ADDR_UNLOCK_A : a, m_addr);
    if (!to)
    begin
      chk_val("status", e, status);
      chk_val("ready_busy_n", 1, {31'h0, rb_n});
      chk_val("late_enough", 1, {31'h0, n > blen});
    end
    while (rb_n !== 1'b1)
      @(negedge clk);
    $display("test %s done", nm);
  endtask : run
  initial
  begin
    void'($urandom(32'h7c17));
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    chk_val("prog_hold_def", 32'h00003a98, HOLD_PROG_CYC_DEF);
    chk_val("acc_hold_def", 32'h000034bc, HOLD_PROG_ACC_CYC_DEF);
    chk_val("erase_hold_def", 32'h07735940, HOLD_ERASE_CYC_DEF);
    run("prog_prompt", OP_PROG, 26'h0012345, 16'h5a81, 1'b0, 10, 1'b0);
    run("prog_slow_acc", OP_PROG, 26'h0012346, 16'h0f70, 1'b1, 300, 1'b0);
    run("sector_erase", OP_SERASE, 26'h0012345, 16'h0000, 1'b0, 400, 1'b0);
    run("reprogram", OP_PROG, 26'h0012346, 16'h00ff, 1'b0, 50, 1'b0);
    run("chip_erase", OP_CERASE, 26'h0012346, 16'h0000, 1'b0, 250, 1'b0);
    for (int i = 0; i < 4; i++)
      run("prog_rand", OP_PROG, 26'($urandom), 16'($urandom), 1'($urandom),
          5 + $urandom_range(200), 1'b0);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd.op <= OP_NONE;
    repeat (20) @(negedge clk);
    chk_val("idle_ready", 1, {31'h0, cmd_ready});
    chk_val("idle_ce_n", 1, {31'h0, ce_n});
    @(posedge clk);
    cmd_valid <= 1'b0;
    $display("test no_op done");
    run("timeout", OP_SERASE, 26'h0020000, 16'h0000, 1'b0, 4000, 1'b1);
    end_of_test();
  end
  initial
  begin
    #240000;
    failures++;
    end_of_test();
  end
endmodule : fes_host_tb_top
